// File: src/dtc_timer.v
`timescale 1ns/10ps
`include "dtc_map.vh"
// ----------------------------------------
// Dual timer/counter with AXI4-Lite registers
// ----------------------------------------
module dtc_timer #(
  parameter ADDR_W = 8,
  parameter PRESCALE = `DTC_PRESCALE_DIV
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write address
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // External count pins
  input wire [1:0] count_pin,
  // Gate pin candidates on port 0 and port 1
  input wire [1:0] gate_pin_port0,
  input wire [1:0] gate_pin_port1,
  // Interrupt service acknowledge
  input wire [1:0] irq_ack,
  // Timer outputs
  output reg [1:0] timer_out,
  output reg [1:0] irq_req,
  output reg baud_tick
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  reg [7:0] tl0;
  reg [7:0] th0;
  reg [7:0] tl1;
  reg [7:0] th1;
  reg [15:0] reload0;
  reg [15:0] reload1;
  reg [7:0] high_buf0;
  reg [7:0] high_buf1;
  reg [1:0] run_bit;
  reg [1:0] overflow_flag;
  reg [7:0] timer_mode_reg;
  reg [1:0] toggle_output_enable;
  reg [1:0] clock_scale_bit;
  reg [1:0] irq_enable;
  reg [1:0] gate_route;
  reg [ADDR_W-1:0] wr_addr;
  reg [31:0] wr_data;
  reg wr_lane0;
  reg aw_held;
  reg w_held;

  // ----------------------------------------
  // Clock sources and pins
  // ----------------------------------------
  wire div_tick;
  wire [5:0] pin_level;
  wire [5:0] pin_fall;

  dtc_prescale #(
    .DIV(PRESCALE)
  ) u_prescale (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(div_tick)
  );

  dtc_pin_sync #(
    .WIDTH(6)
  ) u_pin_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin({gate_pin_port1, gate_pin_port0, count_pin}),
    .level(pin_level),
    .fall(pin_fall)
  );

  // ----------------------------------------
  // Step function shared by both timers
  // ----------------------------------------
  function [16:0] dtc_step;
    input [1:0] mode;
    input [15:0] cnt;
    input [15:0] rld;
    begin
      case (mode)
        `DTC_MODE_RELOAD16: begin
          if (cnt == 16'hffff) begin
            dtc_step = {1'b1, rld};
          end else begin
            dtc_step = {1'b0, cnt + 16'h0001};
          end
        end
        `DTC_MODE_PLAIN16: begin
          dtc_step = {cnt == 16'hffff, cnt + 16'h0001};
        end
        `DTC_MODE_RELOAD8: begin
          if (cnt[7:0] == 8'hff) begin
            dtc_step = {1'b1, cnt[15:8], cnt[15:8]};
          end else begin
            dtc_step = {1'b0, cnt[15:8], cnt[7:0] + 8'h01};
          end
        end
        default: begin
          dtc_step = {cnt[7:0] == 8'hff, cnt[15:8], cnt[7:0] + 8'h01};
        end
      endcase
    end
  endfunction

  // ----------------------------------------
  // Read multiplexer
  // ----------------------------------------
  function [32:0] dtc_read;
    input [ADDR_W-1:0] addr;
    begin
      case (addr)
        `DTC_OFS_CONTROL: begin
          dtc_read = {1'b0, 24'h000000, overflow_flag[1], run_bit[1], overflow_flag[0], run_bit[0], 4'h0};
        end
        `DTC_OFS_CONTROL_EXT: begin
          dtc_read = {1'b0, 24'h000000, 2'h0, toggle_output_enable[1], clock_scale_bit[1],
                      2'h0, toggle_output_enable[0], clock_scale_bit[0]};
        end
        `DTC_OFS_MODE: dtc_read = {1'b0, 24'h000000, timer_mode_reg};
        `DTC_OFS_FIRST_LOW: dtc_read = {1'b0, 24'h000000, tl0};
        `DTC_OFS_FIRST_HIGH: dtc_read = {1'b0, 24'h000000, th0};
        `DTC_OFS_SECOND_LOW: dtc_read = {1'b0, 24'h000000, tl1};
        `DTC_OFS_SECOND_HIGH: dtc_read = {1'b0, 24'h000000, th1};
        `DTC_OFS_PIN_SELECT: dtc_read = {1'b0, 24'h000000, 6'h00, gate_route};
        `DTC_OFS_IRQ_ENABLE: dtc_read = {1'b0, 24'h000000, 6'h00, irq_enable};
        default: dtc_read = {1'b1, 32'h00000000};
      endcase
    end
  endfunction

  // ----------------------------------------
  // Mode decode and count enables
  // ----------------------------------------
  wire [1:0] mode0 = timer_mode_reg[1:0];
  wire [1:0] mode1 = timer_mode_reg[5:4];
  wire split = (mode0 == `DTC_MODE_SPLIT);
  wire gate_in0 = gate_route[0] ? pin_level[4] : pin_level[2];
  wire gate_in1 = gate_route[1] ? pin_level[5] : pin_level[3];
  wire int_tick0 = clock_scale_bit[0] | div_tick;
  wire int_tick1 = clock_scale_bit[1] | div_tick;
  wire src0 = timer_mode_reg[`DTC_BIT_CSEL0] ? pin_fall[0] : int_tick0;
  wire src1 = timer_mode_reg[`DTC_BIT_CSEL1] ? pin_fall[1] : int_tick1;
  wire open0 = run_bit[0] & (~timer_mode_reg[`DTC_BIT_GATE0] | gate_in0);
  wire open1 = run_bit[1] & (~timer_mode_reg[`DTC_BIT_GATE1] | gate_in1);
  wire en0 = open0 & src0;
  wire en1_split = (mode1 != `DTC_MODE_SPLIT) & int_tick1;
  wire en1_plain = open1 & src1 & (mode1 != `DTC_MODE_SPLIT);
  wire en1 = split ? en1_split : en1_plain;
  wire en_th0 = split & run_bit[1] & int_tick0;
  wire [16:0] step0 = dtc_step(mode0, {th0, tl0}, reload0);
  wire [16:0] step1 = dtc_step(mode1, {th1, tl1}, reload1);
  wire ovf0 = en0 & step0[16];
  wire ovf1 = en1 & step1[16];
  wire ovf_th0 = en_th0 & (th0 == 8'hff);
  wire [1:0] flag_set = {split ? ovf_th0 : ovf1, ovf0};

  // ----------------------------------------
  // Register write decode
  // ----------------------------------------
  wire do_write = aw_held & w_held & ~s_axi_bvalid;
  wire wr_ok = do_write & wr_lane0;
  wire [7:0] wbyte = wr_data[7:0];
  wire wr_ctrl = wr_ok & (wr_addr == `DTC_OFS_CONTROL);
  wire wr_l0 = wr_ok & (wr_addr == `DTC_OFS_FIRST_LOW);
  wire wr_h0 = wr_ok & (wr_addr == `DTC_OFS_FIRST_HIGH);
  wire wr_l1 = wr_ok & (wr_addr == `DTC_OFS_SECOND_LOW);
  wire wr_h1 = wr_ok & (wr_addr == `DTC_OFS_SECOND_HIGH);
  wire [32:0] wr_probe = dtc_read(wr_addr);
  wire [32:0] rd_word = dtc_read(s_axi_araddr);
  wire [1:0] flag_base = wr_ctrl ? {wbyte[`DTC_BIT_FLAG1], wbyte[`DTC_BIT_FLAG0]} : overflow_flag;
  // Set beats both clears in the same cycle
  wire [1:0] next_flag = (flag_base & ~irq_ack) | flag_set;

  // ----------------------------------------
  // AXI4-Lite handshakes
  // ----------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `DTC_RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `DTC_RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      wr_addr <= {ADDR_W{1'b0}};
      wr_data <= 32'h00000000;
      wr_lane0 <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_held <= 1'b1;
        wr_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_held <= 1'b1;
        wr_data <= s_axi_wdata;
        wr_lane0 <= s_axi_wstrb[0];
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_probe[32] ? `DTC_RESP_SLVERR : `DTC_RESP_OKAY;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word[31:0];
        s_axi_rresp <= rd_word[32] ? `DTC_RESP_SLVERR : `DTC_RESP_OKAY;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Control registers and flags
  // ----------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      run_bit <= 2'h0;
      overflow_flag <= 2'h0;
      timer_mode_reg <= `DTC_RESET_BYTE;
      toggle_output_enable <= 2'h0;
      clock_scale_bit <= 2'h0;
      irq_enable <= 2'h0;
      gate_route <= 2'h0;
      timer_out <= 2'h0;
      irq_req <= 2'h0;
      baud_tick <= 1'b0;
    end else begin
      overflow_flag <= next_flag;
      irq_req <= next_flag & irq_enable;
      timer_out <= timer_out ^ ({ovf1, ovf0} & toggle_output_enable);
      baud_tick <= ovf1;
      if (wr_ctrl) begin
        // Run bit leaves the count alone
        run_bit <= {wbyte[`DTC_BIT_RUN1], wbyte[`DTC_BIT_RUN0]};
      end
      if (wr_ok && wr_addr == `DTC_OFS_CONTROL_EXT) begin
        toggle_output_enable <= {wbyte[`DTC_BIT_OUT1], wbyte[`DTC_BIT_OUT0]};
        clock_scale_bit <= {wbyte[`DTC_BIT_SCALE1], wbyte[`DTC_BIT_SCALE0]};
      end
      if (wr_ok && wr_addr == `DTC_OFS_MODE) begin
        timer_mode_reg <= wbyte;
      end
      if (wr_ok && wr_addr == `DTC_OFS_PIN_SELECT) begin
        gate_route <= wbyte[1:0];
      end
      if (wr_ok && wr_addr == `DTC_OFS_IRQ_ENABLE) begin
        irq_enable <= wbyte[1:0];
      end
    end
  end

  // ----------------------------------------
  // First timer count and reload
  // ----------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      tl0 <= `DTC_RESET_BYTE;
      th0 <= `DTC_RESET_BYTE;
      reload0 <= 16'h0000;
      high_buf0 <= `DTC_RESET_BYTE;
    end else begin
      if (en0) begin
        tl0 <= step0[7:0];
        if (!split) begin
          th0 <= step0[15:8];
        end
      end
      if (en_th0) begin
        th0 <= th0 + 8'h01;
      end
      // Software writes win over a count in the same cycle, except in 16-bit reload mode, where a running count is never written
      if (mode0 == `DTC_MODE_RELOAD16) begin
        if (wr_h0) begin
          high_buf0 <= wbyte;
        end
        if (wr_l0) begin
          reload0 <= {high_buf0, wbyte};
          if (!run_bit[0]) begin
            {th0, tl0} <= {high_buf0, wbyte};
          end
        end
      end else begin
        if (wr_l0) begin
          tl0 <= wbyte;
        end
        if (wr_h0) begin
          th0 <= wbyte;
        end
      end
    end
  end

  // ----------------------------------------
  // Second timer count and reload
  // ----------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      tl1 <= `DTC_RESET_BYTE;
      th1 <= `DTC_RESET_BYTE;
      reload1 <= 16'h0000;
      high_buf1 <= `DTC_RESET_BYTE;
    end else begin
      if (en1) begin
        {th1, tl1} <= step1[15:0];
      end
      if (mode1 == `DTC_MODE_RELOAD16) begin
        if (wr_h1) begin
          high_buf1 <= wbyte;
        end
        if (wr_l1) begin
          reload1 <= {high_buf1, wbyte};
          if (!run_bit[1]) begin
            {th1, tl1} <= {high_buf1, wbyte};
          end
        end
      end else begin
        if (wr_l1) begin
          tl1 <= wbyte;
        end
        if (wr_h1) begin
          th1 <= wbyte;
        end
      end
    end
  end
endmodule // dtc_timer

// File: src/dtc_map.vh
`ifndef DTC_MAP_VH
`define DTC_MAP_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define DTC_OFS_CONTROL 8'h00
`define DTC_OFS_CONTROL_EXT 8'h04
`define DTC_OFS_MODE 8'h08
`define DTC_OFS_FIRST_LOW 8'h0c
`define DTC_OFS_FIRST_HIGH 8'h10
`define DTC_OFS_SECOND_LOW 8'h14
`define DTC_OFS_SECOND_HIGH 8'h18
`define DTC_OFS_PIN_SELECT 8'h1c
`define DTC_OFS_IRQ_ENABLE 8'h20

// ----------------------------------------
// Field positions
// ----------------------------------------
`define DTC_BIT_FLAG1 7
`define DTC_BIT_RUN1 6
`define DTC_BIT_FLAG0 5
`define DTC_BIT_RUN0 4
`define DTC_BIT_OUT1 5
`define DTC_BIT_SCALE1 4
`define DTC_BIT_OUT0 1
`define DTC_BIT_SCALE0 0
`define DTC_BIT_GATE1 7
`define DTC_BIT_CSEL1 6
`define DTC_BIT_GATE0 3
`define DTC_BIT_CSEL0 2

// ----------------------------------------
// Modes, reset values, timing
// ----------------------------------------
`define DTC_MODE_RELOAD16 2'h0
`define DTC_MODE_PLAIN16 2'h1
`define DTC_MODE_RELOAD8 2'h2
`define DTC_MODE_SPLIT 2'h3
`define DTC_RESET_BYTE 8'h00
`define DTC_PRESCALE_DIV 12
`define DTC_RESP_OKAY 2'h0
`define DTC_RESP_SLVERR 2'h2

`endif

// File: src/dtc_prescale.v
`timescale 1ns/10ps
// ----------------------------------------
// Divide-by-N enable pulse
// ----------------------------------------
module dtc_prescale #(
  parameter DIV = 12
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // One-cycle enable
  output reg tick
);
  reg [7:0] count;

  always @(posedge aclk) begin
    if (!aresetn) begin
      count <= 8'h00;
      tick <= 1'b0;
    end else if (count == DIV[7:0] - 8'h01) begin
      count <= 8'h00;
      tick <= 1'b1;
    end else begin
      count <= count + 8'h01;
      tick <= 1'b0;
    end
  end
endmodule // dtc_prescale

// File: src/dtc_pin_sync.v
`timescale 1ns/10ps
// ----------------------------------------
// Two-flop pin synchroniser with falling edge
// ----------------------------------------
module dtc_pin_sync #(
  parameter WIDTH = 6
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Raw pins
  input wire [WIDTH-1:0] pin,
  // Synchronised level and falling-edge pulse
  output reg [WIDTH-1:0] level,
  output wire [WIDTH-1:0] fall
);
  reg [WIDTH-1:0] meta;
  reg [WIDTH-1:0] last;

  // Edge taken from the second stage and its delayed third-stage copy
  assign fall = last & ~level;

  always @(posedge aclk) begin
    if (!aresetn) begin
      meta <= {WIDTH{1'b0}};
      level <= {WIDTH{1'b0}};
      last <= {WIDTH{1'b0}};
    end else begin
      meta <= pin;
      level <= meta;
      last <= level;
    end
  end
endmodule // dtc_pin_sync

// File: tb/dtc_pin_model.sv
`timescale 1ns/10ps
// ----
// Far-side pins: count pulses, routed gate levels
// ----
module dtc_pin_model #(
  parameter LOW_CYCLES = 3
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Bench requests
  input wire [1:0] pulse_req,
  input wire [1:0] gate_lvl,
  input wire [1:0] route,
  // Pins
  output wire [1:0] count_pin,
  output wire [1:0] gate_pin_port0,
  output wire [1:0] gate_pin_port1
);
  reg [3:0] hold0 = 4'h0;
  reg [3:0] hold1 = 4'h0;
  always @(posedge aclk) begin
    if (!aresetn) begin
      hold0 <= 4'h0;
      hold1 <= 4'h0;
    end else begin
      hold0 <= pulse_req[0] ? 4'(LOW_CYCLES) : ((hold0 == 4'h0) ? 4'h0 : hold0 - 4'h1);
      hold1 <= pulse_req[1] ? 4'(LOW_CYCLES) : ((hold1 == 4'h0) ? 4'h0 : hold1 - 4'h1);
    end
  end
  // Idle high, as on a pulled-up pin
  assign count_pin = {hold1 == 4'h0, hold0 == 4'h0};
  // Unrouted port shows the inverse so a wrong route counts wrongly
  assign gate_pin_port0 = gate_lvl ^ route;
  assign gate_pin_port1 = gate_lvl ^ ~route;
endmodule // dtc_pin_model

// File: tb/dtc_timer_asserts.sv
`timescale 1ns/10ps
// ----
// Port checker
// ----
module dtc_timer_asserts (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Bus
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  // Timer outputs
  input wire [1:0] timer_out,
  input wire baud_tick
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence wr_done;
    s_axi_bvalid && s_axi_bready;
  endsequence
  // Write lands one edge after both are held, so the answer is two edges on
  chk_write_answer: assert property (wr_taken |-> ##2 s_axi_bvalid) else $error("write not answered");
  chk_read_answer: assert property (rd_taken |=> s_axi_rvalid) else $error("read not answered");
  chk_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  chk_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  chk_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read accepted while busy");
  chk_bresp_code: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0 || s_axi_bresp == 2'h2)
    else $error("bad write response code");
  chk_write_reopen: assert property (wr_done |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
    else $error("write channel not reopened");
  chk_read_reopen: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read channel not reopened");
  chk_baud_after_toggle: assert property ($changed(timer_out[1]) |-> baud_tick)
    else $error("second overflow without baud tick");
endmodule // dtc_timer_asserts

bind dtc_timer dtc_timer_asserts u_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .timer_out(timer_out), .baud_tick(baud_tick)
);

// File: tb/dual_timer_counter_with_reload_bench.sv
`timescale 1ns/10ps
module dual_timer_counter_with_reload_bench;
  reg aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid;
  reg [7:0] s_axi_awaddr, s_axi_araddr, h1, l1, h2, l2;
  reg [31:0] s_axi_wdata, rdat;
  reg [1:0] pulse_req, gate_lvl, route, irq_ack, rrsp, brsp;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, baud_tick;
  wire [1:0] s_axi_bresp, s_axi_rresp, timer_out, irq_req, count_pin, gate_p0, gate_p1;
  wire [31:0] s_axi_rdata;
  integer bad_count, tests_run, seed, i, ticks;
  // ----
  // Design and far side
  // ----
  dtc_timer #(.PRESCALE(3)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(1'b1), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(1'b1),
    .count_pin(count_pin), .gate_pin_port0(gate_p0), .gate_pin_port1(gate_p1), .irq_ack(irq_ack),
    .timer_out(timer_out), .irq_req(irq_req), .baud_tick(baud_tick)
  );
  dtc_pin_model u_pins (
    .aclk(aclk), .aresetn(aresetn), .pulse_req(pulse_req), .gate_lvl(gate_lvl), .route(route),
    .count_pin(count_pin), .gate_pin_port0(gate_p0), .gate_pin_port1(gate_p1)
  );
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    if (baud_tick) ticks <= ticks + 1;
  end
  // ----
  // Tasks
  // ----
  task chk(input string nm, input [31:0] exp, input [31:0] got);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  // Both channels offered together; each released at its own handshake
  task wr(input [7:0] a, input [7:0] d);
    reg aw_done, w_done;
    begin
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      aw_done = 1'b0;
      w_done = 1'b0;
      while (!(aw_done && w_done)) begin
        @(posedge aclk);
        if (!aw_done && s_axi_awready) begin
          aw_done = 1'b1;
          s_axi_awvalid <= 1'b0;
        end
        if (!w_done && s_axi_wready) begin
          w_done = 1'b1;
          s_axi_wvalid <= 1'b0;
        end
      end
      do @(posedge aclk); while (!s_axi_bvalid);
      brsp = s_axi_bresp;
    end
  endtask
  task rd(input [7:0] a);
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_rvalid);
      rdat = s_axi_rdata;
      rrsp = s_axi_rresp;
    end
  endtask
  task pulse(input integer n);
    repeat (n) begin
      pulse_req[0] <= 1'b1;
      @(posedge aclk);
      pulse_req[0] <= 1'b0;
      repeat (7) @(posedge aclk);
    end
  endtask
  // Low byte after n increments with 8-bit reload
  function [7:0] exp8(input [7:0] lo, input [7:0] hi, input integer n);
    integer k;
    begin
      exp8 = lo;
      for (k = 0; k < n; k = k + 1) exp8 = (exp8 == 8'hff) ? hi : exp8 + 8'h01;
    end
  endfunction
  task end_sim;
    begin
      if (bad_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  initial begin
    #(80000 * 20);
    bad_count = bad_count + 1;
    end_sim;
  end
  // ----
  // Scenarios
  // ----
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 4'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    {pulse_req, gate_lvl, route, irq_ack} = 8'h0;
    {bad_count, tests_run, ticks} = 0;
    seed = 32;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    for (i = 0; i < 9; i = i + 1) begin
      rd(8'(i * 4));
      chk("reset_value", 32'h0, rdat);
    end
    rd(8'h24);
    chk("unmapped_rresp", 32'h2, 32'(rrsp));
    wr(8'h24, 8'hff);
    chk("unmapped_bresp", 32'h2, 32'(brsp));
    wr(8'h1c, 8'hff);
    rd(8'h1c);
    chk("pin_select", 32'h3, rdat);
    wr(8'h1c, 8'h00);
    for (i = 0; i < 4; i = i + 1) begin
      wr(8'h08, 8'(i * 17));
      rd(8'h08);
      chk("mode_code", 32'(i * 17), rdat);
    end
    wr(8'h08, 8'h00);
    h1 = 8'($random(seed));
    l1 = 8'($random(seed));
    l2 = 8'($random(seed));
    h2 = ~h1;
    wr(8'h10, h1);
    wr(8'h0c, l1);
    rd(8'h10);
    chk("pair_high", 32'(h1), rdat);
    rd(8'h0c);
    chk("pair_low", 32'(l1), rdat);
    wr(8'h10, h2);
    rd(8'h10);
    chk("buffered_high", 32'(h1), rdat);
    wr(8'h0c, l2);
    rd(8'h10);
    chk("commit_high", 32'(h2), rdat);
    wr(8'h0c, l1);
    rd(8'h0c);
    chk("low_alone", 32'(l1), rdat);
    // Running reload: count from f000 overflows after 4096 clocks
    wr(8'h04, 8'h03);
    wr(8'h20, 8'h01);
    wr(8'h10, 8'hf0);
    wr(8'h0c, 8'h00);
    wr(8'h00, 8'h10);
    wr(8'h10, 8'h12);
    wr(8'h0c, 8'h34);
    rd(8'h10);
    chk("run_count_kept", 32'hf0, rdat);
    i = 0;
    // Last read held f0, whose bit 5 would end the poll at once
    rdat = 32'h0;
    while (!rdat[5] && i < 3000) begin
      rd(8'h00);
      i = i + 1;
    end
    chk("irq_raised", 32'h1, 32'(irq_req[0]));
    chk("toggle_out", 32'h1, 32'(timer_out[0]));
    rd(8'h10);
    chk("reloaded_high", 32'h12, rdat);
    irq_ack <= 2'b01;
    @(posedge aclk);
    irq_ack <= 2'b00;
    rd(8'h00);
    chk("flag_cleared", 32'h10, rdat);
    wr(8'h00, 8'h00);
    wr(8'h08, 8'h06);
    wr(8'h0c, 8'hfe);
    wr(8'h10, 8'h80);
    wr(8'h00, 8'h10);
    pulse(3);
    rd(8'h00);
    chk("reload8_flag", 32'h30, rdat);
    wr(8'h00, 8'h00);
    rd(8'h0c);
    chk("reload8_low", 32'(exp8(8'hfe, 8'h80, 3)), rdat);
    rd(8'h10);
    chk("reload8_high", 32'h80, rdat);
    wr(8'h00, 8'h10);
    pulse(1);
    wr(8'h00, 8'h00);
    rd(8'h0c);
    chk("resume_count", 32'(exp8(8'hfe, 8'h80, 4)), rdat);
    chk("toggle_back", 32'h0, 32'(timer_out[0]));
    wr(8'h08, 8'h09);
    wr(8'h0c, 8'h00);
    wr(8'h10, 8'h00);
    wr(8'h00, 8'h10);
    repeat (40) @(posedge aclk);
    wr(8'h00, 8'h00);
    rd(8'h0c);
    chk("gate_closed", 32'h0, rdat);
    wr(8'h1c, 8'h01);
    route <= 2'b01;
    gate_lvl <= 2'b01;
    repeat (4) @(posedge aclk);
    wr(8'h00, 8'h10);
    repeat (40) @(posedge aclk);
    wr(8'h00, 8'h00);
    rd(8'h0c);
    chk("gate_open", 32'h1, 32'(rdat != 0));
    wr(8'h04, 8'h00);
    wr(8'h0c, 8'h00);
    wr(8'h00, 8'h10);
    repeat (60) @(posedge aclk);
    wr(8'h00, 8'h00);
    rd(8'h0c);
    chk("scaled_count", 32'h1, 32'(rdat > 12 && rdat < 30));
    // Split mode; both timers on the full clock
    wr(8'h08, 8'h01);
    wr(8'h04, 8'h31);
    wr(8'h20, 8'h03);
    wr(8'h10, 8'hf0);
    wr(8'h18, 8'hff);
    wr(8'h14, 8'hf0);
    // Second gate enabled and held low: split mode must ignore it
    wr(8'h08, 8'h83);
    i = ticks;
    repeat (100) @(posedge aclk);
    chk("baud_running", 32'h1, 32'(ticks != i));
    rd(8'h00);
    chk("no_second_flag", 32'h0, rdat);
    wr(8'h00, 8'h40);
    repeat (40) @(posedge aclk);
    rd(8'h00);
    chk("split_high_flag", 32'hc0, rdat);
    chk("split_irq", 32'h1, 32'(irq_req[1]));
    wr(8'h08, 8'h33);
    repeat (3) @(posedge aclk);
    i = ticks;
    repeat (100) @(posedge aclk);
    chk("second_stopped", 32'h0, 32'(ticks - i));
    end_sim;
  end
endmodule // dual_timer_counter_with_reload_bench
